// ===== include/qse_params.svh
// constants of the questionable status tree and error queue
`ifndef QSE_PARAMS_SVH
`define QSE_PARAMS_SVH

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define QSE_VOLT_OV_BIT     0
`define QSE_VOLT_UV_BIT     1
`define QSE_TEMP_OT_BIT     0
`define QSE_QUES_VOLT_BIT   0
`define QSE_QUES_TEMP_BIT   4

// ----------------------------------------------------------------------
// implemented bits, everything else reads zero
// ----------------------------------------------------------------------
`define QSE_VOLT_MASK       16'h0003
`define QSE_TEMP_MASK       16'h0001
`define QSE_QUES_MASK       16'h0011

// ----------------------------------------------------------------------
// reset values of enables and transition filters
// ----------------------------------------------------------------------
`define QSE_QUES_ENA_RST    16'h0000
`define QSE_QUES_PTR_RST    16'hffff
`define QSE_QUES_NTR_RST    16'h0000
`define QSE_SUB_ENA_RST     16'hffff
`define QSE_SUB_PTR_RST     16'hffff
`define QSE_SUB_NTR_RST     16'hffff

// ----------------------------------------------------------------------
// error queue
// ----------------------------------------------------------------------
`define QSE_QUEUE_DEPTH     4
`define QSE_NO_ERROR_CODE   16'sh0000
`define QSE_OVERFLOW_CODE   -16'sd350
`define QSE_NO_ERROR_DESC   8'h00
`define QSE_NO_ERROR_LEN    8'h08
`define QSE_OVERFLOW_DESC   8'h01
`define QSE_OVERFLOW_LEN    8'h0e

`endif

// ===== include/qse_pkg.sv
// types shared by the questionable status tree and error queue
package qse_pkg;

  typedef enum logic [3:0] {
    QSE_OP_EVENT_RD,
    QSE_OP_COND_RD,
    QSE_OP_ENA_WR,
    QSE_OP_ENA_RD,
    QSE_OP_PTR_WR,
    QSE_OP_PTR_RD,
    QSE_OP_NTR_WR,
    QSE_OP_NTR_RD,
    QSE_OP_ERR_NEXT,
    QSE_OP_ERR_CODE,
    QSE_OP_ERR_COUNT
  } qse_op_type;

  typedef enum logic [1:0] {
    QSE_SEL_VOLT,
    QSE_SEL_TEMP,
    QSE_SEL_QUES
  } qse_sel_type;

  typedef struct packed {
    qse_op_type  op;
    qse_sel_type sel;
    logic [15:0] data;
  } qse_cmd_type;

  typedef struct packed {
    logic signed [15:0] code;
    logic [7:0]         desc_id;
    logic [7:0]         desc_len;
  } qse_entry_type;

  typedef struct packed {
    logic          with_text;
    qse_entry_type entry;
  } qse_resp_type;

endpackage : qse_pkg

// ===== hw/qse_status_queue.sv
// questionable status tree with voltage and temperature sub-registers plus error queue
`timescale 1ns/1ns
`include "qse_params.svh"

// Contract
// - questionable summary register is sixteen bits wide
// - summary bit 0 reflects the voltage-trip sub-register
// - summary bit 4 reflects the temperature-trip sub-register
// - each summary bit is the OR of its sub-register's enabled event bits
// - voltage bit 0 on over-voltage trip, bit 1 on under-voltage trip
// - temperature bit 0 when critical parts near or exceed maximum temperature
// - entry holds code and description; full query returns both
// - codes are signed 16-bit; zero means no error pending
// - description plus extra text at most 255 characters
// - errors queued in detection order and delivered first in first out
// - on overflow keep oldest, drop newest, last slot becomes -350
// - error queue holds exactly four entries
// - error-queue flag high whenever the queue holds an entry
// - full error query returns oldest entry and removes it
// - code-only query returns oldest code only and removes it

module qse_status_queue #(
  parameter int QUEUE_DEPTH = `QSE_QUEUE_DEPTH
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  over_voltage_trip_i,
  input  wire logic                  under_voltage_trip_i,
  input  wire logic                  over_temp_trip_i,
  input  wire logic                  cmd_valid_i,
  input  wire qse_pkg::qse_cmd_type   cmd_i,
  input  wire logic                  err_push_i,
  input  wire qse_pkg::qse_entry_type err_entry_i,
  output logic                       resp_valid_o,
  output qse_pkg::qse_resp_type       resp_o,
  output logic                       error_queue_flag_o,
  output logic                       ques_summary_o
);

  localparam int CW     = $clog2(QUEUE_DEPTH + 1);
  localparam int NREG   = 3;
  localparam int I_VOLT = 0;
  localparam int I_TEMP = 1;
  localparam int I_QUES = 2;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][2:0]                             sync;
    logic [2:0]                                  pin_stable;
    logic [NREG-1:0][15:0]                       cond;
    logic [NREG-1:0][15:0]                       ptr;
    logic [NREG-1:0][15:0]                       ntr;
    logic [NREG-1:0][15:0]                       ena;
    logic [NREG-1:0][15:0]                       evt;
    qse_pkg::qse_entry_type [QUEUE_DEPTH-1:0]    queue;
    logic [CW-1:0]                               count;
    logic                                        resp_valid;
    qse_pkg::qse_resp_type                       resp;
    logic                                        err_flag;
    logic                                        summary;
  } qse_state_type;

  qse_state_type state_reg;
  qse_state_type state_next;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] impl_mask(input int idx);
    logic [15:0] m;
    m = 16'h0000;
    if (idx == I_VOLT) begin
      m = `QSE_VOLT_MASK;
    end else if (idx == I_TEMP) begin
      m = `QSE_TEMP_MASK;
    end else if (idx == I_QUES) begin
      m = `QSE_QUES_MASK;
    end
    return m;
  endfunction : impl_mask

  function automatic qse_state_type reset_state();
    qse_state_type s;
    s = '0;
    for (int i = 0; i < NREG; i++) begin
      s.ptr[i] = `QSE_SUB_PTR_RST & impl_mask(i);
      s.ntr[i] = `QSE_SUB_NTR_RST & impl_mask(i);
      s.ena[i] = `QSE_SUB_ENA_RST & impl_mask(i);
    end
    s.ptr[I_QUES] = `QSE_QUES_PTR_RST & impl_mask(I_QUES);
    s.ntr[I_QUES] = `QSE_QUES_NTR_RST & impl_mask(I_QUES);
    s.ena[I_QUES] = `QSE_QUES_ENA_RST & impl_mask(I_QUES);
    return s;
  endfunction : reset_state

  function automatic logic sel_is(input qse_pkg::qse_sel_type sel, input int idx);
    return (int'(sel) == idx);
  endfunction : sel_is

  // ----------------------------------------------------------------------
  // working signals of the next-state logic
  // ----------------------------------------------------------------------
  logic [NREG-1:0][15:0]                    cond_new;
  logic [NREG-1:0][15:0]                    evt_set;
  logic [NREG-1:0][15:0]                    evt_clr;
  logic [NREG-1:0]                          sub_sum;
  logic                                     do_pop;
  logic                                     do_write;
  qse_pkg::qse_entry_type [QUEUE_DEPTH-1:0] q_tmp;
  logic [CW-1:0]                            cnt_tmp;
  qse_pkg::qse_entry_type                   head;
  logic [15:0]                              rd_value;

  always_comb begin
    state_next = state_reg;
    cond_new   = '0;
    evt_set    = '0;
    evt_clr    = '0;
    sub_sum    = '0;
    do_pop     = 1'b0;
    do_write   = 1'b0;
    q_tmp      = state_reg.queue;
    cnt_tmp    = state_reg.count;
    head       = '0;
    rd_value   = 16'h0000;

    if (ce_i) begin
      // ------------------------------------------------------------------
      // pin synchronisers: a change counts once stages two and three agree
      // ------------------------------------------------------------------
      state_next.sync[0] = {over_temp_trip_i, under_voltage_trip_i, over_voltage_trip_i};
      state_next.sync[1] = state_reg.sync[0];
      state_next.sync[2] = state_reg.sync[1];
      for (int p = 0; p < 3; p++) begin
        if (state_reg.sync[1][p] == state_reg.sync[2][p]) begin
          state_next.pin_stable[p] = state_reg.sync[2][p];
        end
      end

      // ------------------------------------------------------------------
      // condition registers
      // ------------------------------------------------------------------
      cond_new[I_VOLT][`QSE_VOLT_OV_BIT] = state_reg.pin_stable[0];
      cond_new[I_VOLT][`QSE_VOLT_UV_BIT] = state_reg.pin_stable[1];
      cond_new[I_TEMP][`QSE_TEMP_OT_BIT] = state_reg.pin_stable[2];
      for (int i = 0; i < I_QUES; i++) begin
        sub_sum[i] = |(state_reg.evt[i] & state_reg.ena[i]);
      end
      cond_new[I_QUES][`QSE_QUES_VOLT_BIT] = sub_sum[I_VOLT];
      cond_new[I_QUES][`QSE_QUES_TEMP_BIT] = sub_sum[I_TEMP];

      // ------------------------------------------------------------------
      // transition filters and event latches
      // ------------------------------------------------------------------
      for (int i = 0; i < NREG; i++) begin
        cond_new[i] = cond_new[i] & impl_mask(i);
        evt_set[i]  = ((cond_new[i] & ~state_reg.cond[i] & state_reg.ptr[i])
                    | (~cond_new[i] & state_reg.cond[i] & state_reg.ntr[i]))
                    & impl_mask(i);
        if (cmd_valid_i && cmd_i.op == qse_pkg::QSE_OP_EVENT_RD
            && sel_is(cmd_i.sel, i)) begin
          evt_clr[i] = 16'hffff;
        end
        // an edge in the clearing cycle survives the clear
        state_next.evt[i]  = (state_reg.evt[i] & ~evt_clr[i]) | evt_set[i];
        state_next.cond[i] = cond_new[i];
      end

      // ------------------------------------------------------------------
      // enable and filter writes
      // ------------------------------------------------------------------
      for (int i = 0; i < NREG; i++) begin
        do_write = cmd_valid_i && sel_is(cmd_i.sel, i);
        if (do_write && cmd_i.op == qse_pkg::QSE_OP_ENA_WR) begin
          state_next.ena[i] = cmd_i.data & impl_mask(i);
        end
        if (do_write && cmd_i.op == qse_pkg::QSE_OP_PTR_WR) begin
          state_next.ptr[i] = cmd_i.data & impl_mask(i);
        end
        if (do_write && cmd_i.op == qse_pkg::QSE_OP_NTR_WR) begin
          state_next.ntr[i] = cmd_i.data & impl_mask(i);
        end
      end

      // ------------------------------------------------------------------
      // register reads, answered on the following edge
      // ------------------------------------------------------------------
      for (int i = 0; i < NREG; i++) begin
        if (sel_is(cmd_i.sel, i)) begin
          unique case (cmd_i.op)
            qse_pkg::QSE_OP_EVENT_RD: rd_value = state_reg.evt[i];
            qse_pkg::QSE_OP_COND_RD:  rd_value = state_reg.cond[i];
            qse_pkg::QSE_OP_ENA_RD:   rd_value = state_reg.ena[i];
            qse_pkg::QSE_OP_PTR_RD:   rd_value = state_reg.ptr[i];
            qse_pkg::QSE_OP_NTR_RD:   rd_value = state_reg.ntr[i];
            default:                  rd_value = rd_value;
          endcase
        end
      end

      // ------------------------------------------------------------------
      // error queue: pop first, then push, so a full queue can take one
      // ------------------------------------------------------------------
      do_pop = cmd_valid_i && (cmd_i.op == qse_pkg::QSE_OP_ERR_NEXT
                            || cmd_i.op == qse_pkg::QSE_OP_ERR_CODE);
      if (state_reg.count == '0) begin
        head.code     = `QSE_NO_ERROR_CODE;
        head.desc_id  = `QSE_NO_ERROR_DESC;
        head.desc_len = `QSE_NO_ERROR_LEN;
      end else begin
        head = state_reg.queue[0];
      end
      if (do_pop && state_reg.count != '0) begin
        for (int k = 0; k < QUEUE_DEPTH; k++) begin
          q_tmp[k] = (k + 1 < QUEUE_DEPTH) ? state_reg.queue[k + 1] : '0;
        end
        cnt_tmp = state_reg.count - CW'(1);
      end
      if (err_push_i) begin
        if (int'(cnt_tmp) < QUEUE_DEPTH) begin
          // code and length widths bound the entry, no clamp needed
          q_tmp[cnt_tmp] = err_entry_i;
          cnt_tmp        = cnt_tmp + CW'(1);
        end else begin
          // newest error lost; host still learns that something was dropped
          q_tmp[QUEUE_DEPTH-1].code     = `QSE_OVERFLOW_CODE;
          q_tmp[QUEUE_DEPTH-1].desc_id  = `QSE_OVERFLOW_DESC;
          q_tmp[QUEUE_DEPTH-1].desc_len = `QSE_OVERFLOW_LEN;
        end
      end
      state_next.queue = q_tmp;
      state_next.count = cnt_tmp;

      // ------------------------------------------------------------------
      // answer
      // ------------------------------------------------------------------
      state_next.resp_valid = cmd_valid_i;
      state_next.resp       = '0;
      if (cmd_valid_i) begin
        unique case (cmd_i.op)
          qse_pkg::QSE_OP_ERR_NEXT: begin
            state_next.resp.with_text = 1'b1;
            state_next.resp.entry     = head;
          end
          qse_pkg::QSE_OP_ERR_CODE: begin
            state_next.resp.entry.code = head.code;
          end
          qse_pkg::QSE_OP_ERR_COUNT: begin
            state_next.resp.entry.code = 16'(state_reg.count);
          end
          default: begin
            state_next.resp.entry.code = rd_value;
          end
        endcase
      end

      state_next.err_flag = (cnt_tmp != '0);
      state_next.summary  = |(state_next.evt[I_QUES] & state_next.ena[I_QUES]);
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= reset_state();
    end else begin
      state_reg <= state_next;
    end
  end

  assign resp_valid_o       = state_reg.resp_valid;
  assign resp_o             = state_reg.resp;
  assign error_queue_flag_o = state_reg.err_flag;
  assign ques_summary_o     = state_reg.summary;

endmodule : qse_status_queue

// ===== bench/qse_status_queue_checker.sv
// port checker of the status tree and error queue
`timescale 1ns/1ns
module qse_status_queue_checker #(
  parameter int QUEUE_DEPTH = 4
) (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  ce_i,
  input wire logic                  over_voltage_trip_i,
  input wire logic                  under_voltage_trip_i,
  input wire logic                  over_temp_trip_i,
  input wire logic                  cmd_valid_i,
  input wire qse_pkg::qse_cmd_type   cmd_i,
  input wire logic                  err_push_i,
  input wire qse_pkg::qse_entry_type err_entry_i,
  input wire logic                  resp_valid_o,
  input wire qse_pkg::qse_resp_type  resp_o,
  input wire logic                  error_queue_flag_o,
  input wire logic                  ques_summary_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_answer;
    ce_i && cmd_valid_i |=> resp_valid_o;
  endproperty
  a_answer: assert property (p_answer) else $error("command not answered");
  property p_no_spurious;
    ce_i && !cmd_valid_i |=> !resp_valid_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without command");
  property p_flag_rise;
    ce_i && err_push_i |=> error_queue_flag_o;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag low after push");
  property p_flag_fall;
    $fell(error_queue_flag_o) |-> $past(cmd_valid_i) &&
      ($past(cmd_i.op) inside {qse_pkg::QSE_OP_ERR_NEXT, qse_pkg::QSE_OP_ERR_CODE});
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("queue emptied without pop");
  property p_code_only;
    ce_i && cmd_valid_i && cmd_i.op == qse_pkg::QSE_OP_ERR_CODE |=>
      !resp_o.with_text && resp_o.entry.desc_id == 8'h00 && resp_o.entry.desc_len == 8'h00;
  endproperty
  a_code_only: assert property (p_code_only) else $error("code query carried text");
  property p_full_text;
    ce_i && cmd_valid_i && cmd_i.op == qse_pkg::QSE_OP_ERR_NEXT |=> resp_o.with_text;
  endproperty
  a_full_text: assert property (p_full_text) else $error("full query without text");
  property p_count_bound;
    ce_i && cmd_valid_i && cmd_i.op == qse_pkg::QSE_OP_ERR_COUNT |=>
      resp_o.entry.code >= 0 && resp_o.entry.code <= QUEUE_DEPTH;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count beyond depth");
  property p_empty_zero;
    ce_i && cmd_valid_i && !error_queue_flag_o &&
      cmd_i.op inside {qse_pkg::QSE_OP_ERR_NEXT, qse_pkg::QSE_OP_ERR_CODE} |=>
      resp_o.entry.code == 16'sh0000;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty queue gave nonzero");
  property p_ques_mask;
    ce_i && cmd_valid_i && cmd_i.sel == qse_pkg::QSE_SEL_QUES &&
      cmd_i.op == qse_pkg::QSE_OP_COND_RD |=> (resp_o.entry.code & 16'hffee) == 16'h0000;
  endproperty
  a_ques_mask: assert property (p_ques_mask) else $error("unused summary bit set");
endmodule : qse_status_queue_checker

bind qse_status_queue qse_status_queue_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .over_voltage_trip_i(over_voltage_trip_i),
  .under_voltage_trip_i(under_voltage_trip_i), .over_temp_trip_i(over_temp_trip_i),
  .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .err_push_i(err_push_i),
  .err_entry_i(err_entry_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
  .error_queue_flag_o(error_queue_flag_o), .ques_summary_o(ques_summary_o));

// ===== bench/qse_host_model.sv
// host model issuing status and error queue commands
`timescale 1ns/1ns
module qse_host_model (
  input  wire logic                 clk_i,
  input  wire logic                 resp_valid_i,
  input  wire qse_pkg::qse_resp_type resp_i,
  output logic                      cmd_valid_o,
  output qse_pkg::qse_cmd_type       cmd_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o       = '0;
  end

  task automatic issue(input qse_pkg::qse_op_type op, input qse_pkg::qse_sel_type sel,
                       input logic [15:0] data, output logic got,
                       output qse_pkg::qse_resp_type resp);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_o       = '{op, sel, data};
    @(negedge clk_i);
    got         = resp_valid_i;
    resp        = resp_i;
    cmd_valid_o = 1'b0;
    // stale fields inverted so nothing leans on a held command
    cmd_o       = ~cmd_o;
  endtask : issue
endmodule : qse_host_model

// ===== bench/tb_questionable_status_error_queue.sv
// self-checking bench of the status tree and error queue
`timescale 1ns/1ns
`include "qse_params.svh"
module tb_questionable_status_error_queue;
  typedef struct packed {
    qse_pkg::qse_op_type  op;
    qse_pkg::qse_sel_type sel;
    logic [15:0]          data;
    logic [15:0]          exp;
  } qse_row_type;

  logic                   clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ovt = 1'b0, uvt = 1'b0;
  logic                   otp = 1'b0, push = 1'b0, cmd_valid, resp_valid, flag, summary;
  qse_pkg::qse_cmd_type   cmd;
  qse_pkg::qse_entry_type entry = '0;
  qse_pkg::qse_resp_type  resp;
  qse_row_type            rows [10];
  int                     err_count = 0, checked = 0, cycles = 0;

  initial forever #50 clk = ~clk;

  qse_status_queue dut_u (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .over_voltage_trip_i(ovt), .under_voltage_trip_i(uvt), .over_temp_trip_i(otp),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .err_push_i(push), .err_entry_i(entry),
    .resp_valid_o(resp_valid), .resp_o(resp), .error_queue_flag_o(flag),
    .ques_summary_o(summary));
  qse_host_model host_u (.clk_i(clk), .resp_valid_i(resp_valid), .resp_i(resp),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd));

  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cmd_chk(input qse_pkg::qse_op_type op, input qse_pkg::qse_sel_type sel,
                         input logic [15:0] data, input logic [15:0] exp);
    logic                  got;
    qse_pkg::qse_resp_type r;
    host_u.issue(op, sel, data, got, r);
    check("resp_valid", 16'h0001, {15'h0000, got});
    check("resp_code", exp, r.entry.code);
    if (op == qse_pkg::QSE_OP_ERR_NEXT) check("with_text", 16'h0001, {15'h0, r.with_text});
  endtask : cmd_chk

  task automatic settle;
    repeat (10) @(negedge clk);
  endtask : settle

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("[ERR] timeout expected finish seen hang");
      complete_run();
    end
  end

  initial begin
    rows = '{
      '{qse_pkg::QSE_OP_ENA_RD, qse_pkg::QSE_SEL_VOLT, 16'h0000, 16'h0003},
      '{qse_pkg::QSE_OP_PTR_RD, qse_pkg::QSE_SEL_TEMP, 16'h0000, 16'h0001},
      '{qse_pkg::QSE_OP_NTR_RD, qse_pkg::QSE_SEL_QUES, 16'h0000, 16'h0000},
      '{qse_pkg::QSE_OP_PTR_RD, qse_pkg::QSE_SEL_QUES, 16'h0000, 16'h0011},
      '{qse_pkg::QSE_OP_ENA_WR, qse_pkg::QSE_SEL_QUES, 16'hffff, 16'h0000},
      '{qse_pkg::QSE_OP_ENA_RD, qse_pkg::QSE_SEL_QUES, 16'h0000, 16'h0011},
      '{qse_pkg::QSE_OP_ERR_COUNT, qse_pkg::QSE_SEL_VOLT, 16'h0000, 16'h0000},
      '{qse_pkg::QSE_OP_ERR_NEXT, qse_pkg::QSE_SEL_VOLT, 16'h0000, 16'h0000},
      '{qse_pkg::QSE_OP_ERR_CODE, qse_pkg::QSE_SEL_VOLT, 16'h0000, 16'h0000},
      '{qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_QUES, 16'h0000, 16'h0000}};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) cmd_chk(rows[i].op, rows[i].sel, rows[i].data, rows[i].exp);
    $display("register table done");
    ovt = 1'b1;
    settle();
    cmd_chk(qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0001);
    cmd_chk(qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_QUES, 16'h0, 16'h0001);
    check("summary", 16'h0001, {15'h0, summary});
    uvt = 1'b1;
    otp = 1'b1;
    settle();
    cmd_chk(qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0003);
    cmd_chk(qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_TEMP, 16'h0, 16'h0001);
    cmd_chk(qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_QUES, 16'h0, 16'h0011);
    cmd_chk(qse_pkg::QSE_OP_EVENT_RD, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0003);
    cmd_chk(qse_pkg::QSE_OP_EVENT_RD, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0000);
    cmd_chk(qse_pkg::QSE_OP_EVENT_RD, qse_pkg::QSE_SEL_QUES, 16'h0, 16'h0011);
    ovt = 1'b0;
    settle();
    // falling over-voltage is a negative-filter event, so the voltage summary returns
    cmd_chk(qse_pkg::QSE_OP_COND_RD, qse_pkg::QSE_SEL_QUES, 16'h0, 16'h0011);
    cmd_chk(qse_pkg::QSE_OP_EVENT_RD, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0001);
    $display("status tree done");
    for (int i = 1; i <= 5; i++) begin
      @(negedge clk);
      push  = 1'b1;
      entry = '{i[15:0], 8'h10, 8'h05};
    end
    @(negedge clk);
    push = 1'b0;
    check("flag", 16'h0001, {15'h0, flag});
    cmd_chk(qse_pkg::QSE_OP_ERR_COUNT, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0004);
    cmd_chk(qse_pkg::QSE_OP_ERR_NEXT, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0001);
    cmd_chk(qse_pkg::QSE_OP_ERR_CODE, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0002);
    cmd_chk(qse_pkg::QSE_OP_ERR_NEXT, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0003);
    cmd_chk(qse_pkg::QSE_OP_ERR_NEXT, qse_pkg::QSE_SEL_VOLT, 16'h0, `QSE_OVERFLOW_CODE);
    check("flag", 16'h0000, {15'h0, flag});
    $display("error queue done");
    // a push while the enable is low must leave the queue untouched
    ce = 1'b0;
    @(negedge clk);
    push  = 1'b1;
    entry = '{16'sh0007, 8'h10, 8'h05};
    @(negedge clk);
    push = 1'b0;
    check("frozen flag", 16'h0000, {15'h0, flag});
    ce = 1'b1;
    cmd_chk(qse_pkg::QSE_OP_ERR_COUNT, qse_pkg::QSE_SEL_VOLT, 16'h0, 16'h0000);
    $display("clock enable done");
    complete_run();
  end
endmodule : tb_questionable_status_error_queue
